/* File: include/cms_defs.vh */
// Constants for the charger mode sequencer: offsets, fields, resets, timing
`ifndef CMS_DEFS_VH
`define CMS_DEFS_VH
// Register offsets (byte addresses on the plain register port)
`define CMS_OFF_OPT0 8'h00
`define CMS_OFF_OPT1 8'h01
`define CMS_OFF_CHG_I 8'h02
`define CMS_OFF_CHG_V 8'h04
`define CMS_OFF_VIN_REG 8'h0A
`define CMS_OFF_MINSYS 8'h0C
`define CMS_OFF_HOST_INPUT_CURRENT_LIMIT 8'h0E
`define CMS_OFF_AWAKE 8'h30
`define CMS_OFF_PINCTL 8'h32
`define CMS_OFF_HIZCTL 8'h35
`define CMS_OFF_STATUS 8'h40
`define CMS_OFF_IIN_EFF 8'h42
`define CMS_OFF_SYSTEM_OVERVOLTAGE_THRESHOLD 8'h44
// Field positions
`define CMS_BIT_INHIBIT 0
`define CMS_BIT_LINEAR 2
`define CMS_BIT_LOWPWR 7
`define CMS_BIT_AWAKE 0
`define CMS_BIT_PIN_EN 7
`define CMS_BIT_HIZ 7
// Reset values; currents in 1mA units, input current code in 50mA steps, voltages in 1mV units
`define CMS_RST_IIN_CODE 7'h42
`define CMS_IIN_STEP_MA 16'h0032
`define CMS_AWAKE_I_MA 16'h0080
`define CMS_CLAMP_LO_MA 16'h0180
`define CMS_CLAMP_HI_MA 16'h07D0
`define CMS_ONE_CELL_LOW_MV 16'h0BB8
`define CMS_SYS_MARGIN_MV 16'h00A0
// Cell defaults: charge voltage, minimum system, system overvoltage
`define CMS_V4_CHG 16'h41A0
`define CMS_V3_CHG 16'h3130
`define CMS_V2_CHG 16'h20D0
`define CMS_V1_CHG 16'h1060
`define CMS_V4_MIN 16'h3002
`define CMS_V3_MIN 16'h2400
`define CMS_V2_MIN 16'h1800
`define CMS_V1_MIN 16'h0E00
`define CMS_V4_OVP 16'h4C2C
`define CMS_V3_OVP 16'h4C2C
`define CMS_V2_OVP 16'h2EE0
`define CMS_V1_OVP 16'h1388
// Cell-sense codes from the comparator bank
`define CMS_CELL_4 2'h3
`define CMS_CELL_3 2'h2
`define CMS_CELL_2 2'h1
`define CMS_CELL_1 2'h0
// Timing in ms, auto-wake in minutes, and clock rate in kHz
`define CMS_CLK_KHZ 25000
`define CMS_GOOD_MS 50
`define CMS_DEBOUNCE_MS 150
`define CMS_AWAKE_MIN 30
`define CMS_MS_PER_MIN 36'h0_0000_EA60
`endif

/* File: logic/cms_sequencer.v */
// Charger mode sequencer: power-up, high-impedance, limits, cells, charge modes
`timescale 1ns/100ps
`include "cms_defs.vh"

// How it works
// - Battery only: low power, battery switch on
// - Low-power bit cleared enables performance mode
// - Adapter over threshold starts detection unless high-impedance
// - Adapter good after 50ms, start after 150ms
// - Pin low or enable bit stops switching
// - Effective input limit is lower of two
// - Host input limit: 7 bits, 50mA, 3.3A
// - One-shot pin sample sets high-impedance mode
// - Pin ignored when disabled or above 4V
// - Load measured input regulation voltage, host overwritable
// - Load cell defaults unless host already wrote
// - Decode cell-sense ratio into defaults
// - Overvoltage threshold locked once configured
// - Charging below minimum: linear, 384mA clamp, 2000mA for one cell at 3V or more
// - Charging disabled while switching: battery switch off
// - Zero current or inhibit disables charging
// - Low battery at attach: 128mA for 30 mins
// - Four events end auto-wake, clear bit, current
// - Pre-charge clamps by cell count and voltage
// - Charge current cleared on removal, pin, zero
// - Zero charge voltage reloads default, clears current
module cms_sequencer #(
  parameter GOOD_CYCLES = `CMS_GOOD_MS * `CMS_CLK_KHZ,
  parameter DEBOUNCE_CYCLES = `CMS_DEBOUNCE_MS * `CMS_CLK_KHZ,
  parameter [35:0] AWAKE_CYCLES = `CMS_AWAKE_MIN * `CMS_MS_PER_MIN * `CMS_CLK_KHZ
) (
  // Clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // Register port
  input wire [7:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [15:0] reg_rdata_out,
  // Adapter and battery comparators
  input wire adapter_conv_in,
  input wire adapter_ovp_in,
  input wire battery_uvlo_ok_in,
  input wire batt_below_minsys_in,
  input wire batt_below_3v_in,
  input wire battery_config_pin_low_in,
  // One-shot converter results
  input wire [1:0] cell_count_sense_pin_in,
  input wire [15:0] adapter_rail_mv_in,
  input wire current_limit_pin_below_lo_in,
  input wire current_limit_pin_above_hi_in,
  input wire current_limit_pin_above_4v_in,
  input wire [15:0] current_limit_pin_ma_in,
  // Control outputs
  output reg adapter_good_output_out,
  output reg converter_run_out,
  output reg poor_source_detect_out,
  output wire battery_switch_on_out,
  output wire battery_switch_linear_out,
  output wire gate_drive_supply_full_out,
  output wire monitors_allowed_out,
  output wire high_impedance_out,
  output wire [15:0] input_current_regulation_ma_out,
  output wire [15:0] charge_current_ma_out,
  output wire [15:0] system_target_mv_out,
  output wire system_target_tracks_batt_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  localparam ST_IDLE = 3'd0;
  localparam ST_GOOD = 3'd1;
  localparam ST_SETUP = 3'd2;
  localparam ST_DEBOUNCE = 3'd3;
  localparam ST_RUN = 3'd4;

  reg [2:0] state_reg;
  reg [31:0] timer_reg;
  reg [35:0] awake_cnt_reg; // Half an hour of clock overflows 32 bits
  reg awake_active_reg;
  reg [15:0] opt0_reg;
  reg [15:0] opt1_reg;
  reg [15:0] chg_i_reg;
  reg [15:0] chg_v_reg;
  reg [15:0] vin_reg_reg;
  reg [15:0] minsys_reg;
  reg [6:0] iin_code_reg;
  reg awake_en_reg;
  reg pin_en_reg;
  reg hiz_bit_reg;
  reg pin_hiz_reg;
  reg pin_ignore_reg;
  reg [15:0] pin_ma_reg;
  reg [15:0] system_overvoltage_threshold_reg;
  reg ovp_locked_reg;
  reg chg_v_host_reg;
  reg minsys_host_reg;
  reg [15:0] def_chg_reg;
  reg [1:0] cells_reg;
  reg [15:0] d_chg;
  reg [15:0] d_min;
  reg [15:0] d_ovp;

  wire adapter_ok = adapter_conv_in & ~adapter_ovp_in;
  wire wr_chg_i = reg_wr_in & (reg_addr_in == `CMS_OFF_CHG_I);
  wire wr_chg_v = reg_wr_in & (reg_addr_in == `CMS_OFF_CHG_V);
  wire wr_awake = reg_wr_in & (reg_addr_in == `CMS_OFF_AWAKE);
  wire awake_done = awake_cnt_reg >= AWAKE_CYCLES - 1;
  wire awake_exit = awake_active_reg & ((wr_awake & ~reg_wdata_in[`CMS_BIT_AWAKE])
    | wr_chg_i | ~batt_below_minsys_in | awake_done);
  wire clr_chg_i = ~adapter_conv_in | battery_config_pin_low_in
    | (wr_chg_v & (reg_wdata_in == 16'h0000));

  ////////////////////////////////////////////////////////////////////////////
  // Cell decode
  // ratio code to defaults
  always @* begin
    case (cell_count_sense_pin_in)
      `CMS_CELL_4: begin
        d_chg = `CMS_V4_CHG;
        d_min = `CMS_V4_MIN;
        d_ovp = `CMS_V4_OVP;
      end
      `CMS_CELL_3: begin
        d_chg = `CMS_V3_CHG;
        d_min = `CMS_V3_MIN;
        d_ovp = `CMS_V3_OVP;
      end
      `CMS_CELL_2: begin
        d_chg = `CMS_V2_CHG;
        d_min = `CMS_V2_MIN;
        d_ovp = `CMS_V2_OVP;
      end
      default: begin
        d_chg = `CMS_V1_CHG;
        d_min = `CMS_V1_MIN;
        d_ovp = `CMS_V1_OVP;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // High-impedance and mode decisions
  // pin low or enable bit
  assign high_impedance_out = hiz_bit_reg | (pin_hiz_reg & ~pin_ignore_reg);
  assign gate_drive_supply_full_out = ~opt1_reg[`CMS_BIT_LOWPWR];
  assign monitors_allowed_out = ~opt1_reg[`CMS_BIT_LOWPWR];
  wire chg_enabled = (chg_i_reg != 16'h0000) & ~opt0_reg[`CMS_BIT_INHIBIT];
  wire linear_mode = opt0_reg[`CMS_BIT_LINEAR];
  // battery-only and high-impedance keep switch on
  wire batt_only = ~adapter_conv_in & battery_uvlo_ok_in;
  // switch off when disabled with adapter running
  assign battery_switch_on_out = batt_only | high_impedance_out
    | ~converter_run_out | chg_enabled;
  assign battery_switch_linear_out = converter_run_out & chg_enabled
    & batt_below_minsys_in & linear_mode;
  assign system_target_mv_out = minsys_reg + `CMS_SYS_MARGIN_MV;
  assign system_target_tracks_batt_out = ~batt_below_minsys_in;

  ////////////////////////////////////////////////////////////////////////////
  // Charge current clamp
  // pre-charge clamp by cells
  wire [15:0] clamp_ma = (cells_reg == `CMS_CELL_1 && !batt_below_3v_in) ?
    `CMS_CLAMP_HI_MA : `CMS_CLAMP_LO_MA;
  wire clamp_on = linear_mode & batt_below_minsys_in;
  wire [15:0] chg_req = chg_enabled ? chg_i_reg : 16'h0000;
  assign charge_current_ma_out = (clamp_on && chg_req > clamp_ma) ? clamp_ma : chg_req;

  ////////////////////////////////////////////////////////////////////////////
  // Input current limit
  // code times 50mA
  wire [15:0] host_ma = iin_code_reg * `CMS_IIN_STEP_MA;
  assign input_current_regulation_ma_out =
    (!pin_ignore_reg && pin_ma_reg < host_ma) ? pin_ma_reg : host_ma;

  ////////////////////////////////////////////////////////////////////////////
  // Power-up sequencer
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      timer_reg <= 32'h0000_0000;
      adapter_good_output_out <= 1'b0;
      converter_run_out <= 1'b0;
      poor_source_detect_out <= 1'b0;
      pin_hiz_reg <= 1'b0;
      pin_ignore_reg <= 1'b1;
      pin_ma_reg <= 16'hFFFF;
      cells_reg <= `CMS_CELL_1;
    end else if (!adapter_conv_in) begin
      state_reg <= ST_IDLE;
      timer_reg <= 32'h0000_0000;
      adapter_good_output_out <= 1'b0;
      converter_run_out <= 1'b0;
      poor_source_detect_out <= 1'b0;
    end else begin
      poor_source_detect_out <= ~high_impedance_out;
      case (state_reg)
        ST_IDLE: begin
          timer_reg <= 32'h0000_0000;
          if (adapter_ok) begin
            state_reg <= ST_GOOD;
          end
        end
        ST_GOOD: begin
          if (!adapter_ok) begin
            state_reg <= ST_IDLE;
          end else if (timer_reg >= GOOD_CYCLES - 1) begin
            adapter_good_output_out <= 1'b1;
            timer_reg <= 32'h0000_0000;
            state_reg <= ST_SETUP;
          end else begin
            timer_reg <= timer_reg + 32'h0000_0001;
          end
        end
        ST_SETUP: begin
          pin_ignore_reg <= ~pin_en_reg | current_limit_pin_above_4v_in;
          pin_ma_reg <= current_limit_pin_ma_in;
          if (current_limit_pin_below_lo_in) begin
            pin_hiz_reg <= 1'b1;
          end else if (current_limit_pin_above_hi_in) begin
            pin_hiz_reg <= 1'b0;
          end
          cells_reg <= cell_count_sense_pin_in;
          state_reg <= ST_DEBOUNCE;
        end
        ST_DEBOUNCE: begin
          if (timer_reg >= DEBOUNCE_CYCLES - 1) begin
            state_reg <= ST_RUN;
          end else begin
            timer_reg <= timer_reg + 32'h0000_0001;
          end
        end
        ST_RUN: begin
          converter_run_out <= ~high_impedance_out;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  wire setup_now = adapter_conv_in & (state_reg == ST_SETUP);
  wire run_start = adapter_conv_in & (state_reg == ST_DEBOUNCE)
    & (timer_reg >= DEBOUNCE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Auto-wake timer
  // restart on entry, stop on exit
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      awake_active_reg <= 1'b0;
      awake_cnt_reg <= 36'h0_0000_0000;
    end else if (awake_exit || !adapter_conv_in) begin
      awake_active_reg <= 1'b0;
      awake_cnt_reg <= 36'h0_0000_0000;
    end else if (run_start && awake_en_reg && batt_below_minsys_in) begin
      awake_active_reg <= 1'b1;
      awake_cnt_reg <= 36'h0_0000_0000;
    end else if (awake_active_reg) begin
      awake_cnt_reg <= awake_cnt_reg + 36'h0_0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and hardware updates
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      opt0_reg <= 16'h0004;
      opt1_reg <= 16'h0080;
      chg_i_reg <= 16'h0000;
      chg_v_reg <= `CMS_V1_CHG;
      vin_reg_reg <= 16'h0000;
      minsys_reg <= `CMS_V1_MIN;
      iin_code_reg <= `CMS_RST_IIN_CODE;
      awake_en_reg <= 1'b1;
      pin_en_reg <= 1'b1;
      hiz_bit_reg <= 1'b0;
      system_overvoltage_threshold_reg <= `CMS_V1_OVP;
      ovp_locked_reg <= 1'b0;
      chg_v_host_reg <= 1'b0;
      minsys_host_reg <= 1'b0;
      def_chg_reg <= `CMS_V1_CHG;
    end else begin
      if (reg_wr_in) begin
        case (reg_addr_in)
          `CMS_OFF_OPT0: opt0_reg <= reg_wdata_in;
          `CMS_OFF_OPT1: opt1_reg <= reg_wdata_in;
          `CMS_OFF_CHG_I: chg_i_reg <= reg_wdata_in;
          `CMS_OFF_VIN_REG: vin_reg_reg <= reg_wdata_in;
          `CMS_OFF_HOST_INPUT_CURRENT_LIMIT: iin_code_reg <= reg_wdata_in[6:0];
          `CMS_OFF_AWAKE: awake_en_reg <= reg_wdata_in[`CMS_BIT_AWAKE];
          `CMS_OFF_PINCTL: pin_en_reg <= reg_wdata_in[`CMS_BIT_PIN_EN];
          `CMS_OFF_HIZCTL: hiz_bit_reg <= reg_wdata_in[`CMS_BIT_HIZ];
          `CMS_OFF_MINSYS: begin
            minsys_reg <= reg_wdata_in;
            minsys_host_reg <= 1'b1;
          end
          `CMS_OFF_CHG_V: begin
            chg_v_reg <= (reg_wdata_in == 16'h0000) ? def_chg_reg : reg_wdata_in;
            chg_v_host_reg <= 1'b1;
          end
          default: begin
          end
        endcase
      end
      if (setup_now) begin
        vin_reg_reg <= adapter_rail_mv_in;
      end
      if (setup_now) begin
        def_chg_reg <= d_chg;
        if (!chg_v_host_reg) begin
          chg_v_reg <= d_chg;
        end
        if (!minsys_host_reg) begin
          minsys_reg <= d_min;
        end
        if (!ovp_locked_reg) begin
          system_overvoltage_threshold_reg <= d_ovp;
          ovp_locked_reg <= 1'b1;
        end
      end
      if (run_start && awake_en_reg && batt_below_minsys_in) begin
        chg_i_reg <= `CMS_AWAKE_I_MA;
      end
      if (awake_exit) begin
        awake_en_reg <= 1'b0;
        chg_i_reg <= 16'h0000;
      end
      if (clr_chg_i) begin
        chg_i_reg <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped reads zero
  always @(posedge clk_in) begin
    if (sys_rst_in || !reg_rd_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      case (reg_addr_in)
        `CMS_OFF_OPT0: reg_rdata_out <= opt0_reg;
        `CMS_OFF_OPT1: reg_rdata_out <= opt1_reg;
        `CMS_OFF_CHG_I: reg_rdata_out <= chg_i_reg;
        `CMS_OFF_CHG_V: reg_rdata_out <= chg_v_reg;
        `CMS_OFF_VIN_REG: reg_rdata_out <= vin_reg_reg;
        `CMS_OFF_MINSYS: reg_rdata_out <= minsys_reg;
        `CMS_OFF_HOST_INPUT_CURRENT_LIMIT: reg_rdata_out <= {9'h000, iin_code_reg};
        `CMS_OFF_AWAKE: reg_rdata_out <= {15'h0000, awake_en_reg};
        `CMS_OFF_PINCTL: reg_rdata_out <= {8'h00, pin_en_reg, 7'h00};
        `CMS_OFF_HIZCTL: reg_rdata_out <= {8'h00, hiz_bit_reg, 7'h00};
        `CMS_OFF_STATUS: reg_rdata_out <= {8'h00, awake_active_reg, state_reg,
          high_impedance_out, converter_run_out, adapter_good_output_out,
          ovp_locked_reg};
        `CMS_OFF_IIN_EFF: reg_rdata_out <= input_current_regulation_ma_out;
        `CMS_OFF_SYSTEM_OVERVOLTAGE_THRESHOLD: reg_rdata_out <= system_overvoltage_threshold_reg;
        default: reg_rdata_out <= 16'h0000;
      endcase
    end
  end

endmodule

/* File: tb/cms_seq_props.sv */
// Checker for the charger mode sequencer ports
`timescale 1ns/100ps
`include "cms_defs.vh"
module cms_seq_props #(
  parameter GOOD_CYCLES = 20,
  parameter DEBOUNCE_CYCLES = 30
) (
  // Clock, reset and sensed inputs
  input wire clk_in,
  input wire sys_rst_in,
  input wire adapter_conv_in,
  input wire adapter_ovp_in,
  input wire battery_config_pin_low_in,
  input wire [7:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  // Observed outputs
  input wire adapter_good_output_out,
  input wire converter_run_out,
  input wire gate_drive_supply_full_out,
  input wire monitors_allowed_out,
  input wire high_impedance_out,
  input wire [15:0] charge_current_ma_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  reg [15:0] ok_cnt_reg;
  reg [15:0] good_cnt_reg;
  ////////////////////////////////////////////////////////////////
  // Run lengths of a clean adapter and of adapter good
  always @(posedge clk_in) begin
    ok_cnt_reg <= (sys_rst_in || !adapter_conv_in || adapter_ovp_in) ? 16'h0000
      : ok_cnt_reg + 16'h0001;
    good_cnt_reg <= (sys_rst_in || !adapter_good_output_out) ? 16'h0000
      : good_cnt_reg + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////
  // good after delay
  a_good_delay: assert property (
    $rose(adapter_good_output_out) |-> ok_cnt_reg >= GOOD_CYCLES)
    else $error("adapter good raised too early");
  a_run_delay: assert property (
    $rose(converter_run_out) |-> good_cnt_reg >= DEBOUNCE_CYCLES)
    else $error("converter started too early");
  a_ovp_hold: assert property (
    adapter_ovp_in && !adapter_good_output_out |=> !adapter_good_output_out)
    else $error("good raised above overvoltage");
  a_drop_removal: assert property (
    !adapter_conv_in |=> !adapter_good_output_out && !converter_run_out)
    else $error("outputs held after adapter removal");
  a_hiz_stop: assert property (
    high_impedance_out [*2] |-> !converter_run_out)
    else $error("switching in high impedance");
  a_removal_clear: assert property (
    $fell(adapter_conv_in) |=> charge_current_ma_out == 16'h0000)
    else $error("charge current kept after removal");
  a_cfg_clear: assert property (
    $rose(battery_config_pin_low_in) |=> charge_current_ma_out == 16'h0000)
    else $error("charge current kept after config pin low");
  a_perf_gate: assert property (
    reg_wr_in && reg_addr_in == `CMS_OFF_OPT1
      |=> gate_drive_supply_full_out == !$past(reg_wdata_in[`CMS_BIT_LOWPWR])
      && monitors_allowed_out == gate_drive_supply_full_out)
    else $error("performance mode does not follow low power bit");
endmodule
bind cms_sequencer cms_seq_props #(
  .GOOD_CYCLES(GOOD_CYCLES),
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) u_props (
  .clk_in(clk_in),
  .sys_rst_in(sys_rst_in),
  .adapter_conv_in(adapter_conv_in),
  .adapter_ovp_in(adapter_ovp_in),
  .battery_config_pin_low_in(battery_config_pin_low_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .adapter_good_output_out(adapter_good_output_out),
  .converter_run_out(converter_run_out),
  .gate_drive_supply_full_out(gate_drive_supply_full_out),
  .monitors_allowed_out(monitors_allowed_out),
  .high_impedance_out(high_impedance_out),
  .charge_current_ma_out(charge_current_ma_out)
);

/* File: tb/cms_sense_model.sv */
// Adapter and battery sensing model feeding the comparator inputs
`timescale 1ns/100ps
module cms_sense_model #(
  parameter [15:0] RAIL_MV = 16'h4E20
) (
  // Commands from the bench
  input wire clk_in,
  input wire plug_in,
  input wire surge_in,
  input wire [15:0] batt_mv_in,
  input wire [15:0] minsys_mv_in,
  // Comparator and converter results
  output reg conv_out = 1'b0,
  output reg ovp_out = 1'b0,
  output reg [15:0] rail_mv_out = 16'h0000,
  output reg below_minsys_out = 1'b0,
  output reg below_3v_out = 1'b0
);
  // Comparators settle one clock late, so no edge sees them move early
  always @(posedge clk_in) begin
    conv_out <= plug_in;
    ovp_out <= plug_in && surge_in;
    rail_mv_out <= plug_in ? RAIL_MV : 16'h0000;
    below_minsys_out <= batt_mv_in < minsys_mv_in;
    below_3v_out <= batt_mv_in < 16'h0BB8;
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the charger mode sequencer
`timescale 1ns/100ps
`include "cms_defs.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  localparam GOOD = 20;
  localparam DEB = 30;
  localparam AWK = 100;
  reg clk_in = 1'b0;
  reg sys_rst_in = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg rd_d = 1'b0;
  reg plug = 1'b0;
  reg surge = 1'b0;
  reg cfg_low = 1'b0;
  reg pin_lo = 1'b0;
  reg pin_hi = 1'b1;
  reg [1:0] cells = 2'h0;
  reg [15:0] batt_mv = 16'h1000;
  reg [15:0] minsys_mv = 16'h0E00;
  reg [15:0] pin_ma = 16'h0800;
  reg pin_4v = 1'b0;
  wire conv, ovp, b_min, b_3v, good, run, psd, sw_on, sw_lin, gdrv, hiz, trk;
  wire [15:0] rail, rdata, ilim, chg, tgt;
  wire [1:0] st = {run, good};
  logic [15:0] exp_q[$];
  logic [15:0] q_exp, code, v;
  logic [15:0] vchg [0:3] = '{`CMS_V1_CHG, `CMS_V2_CHG, `CMS_V3_CHG, `CMS_V4_CHG};
  logic [15:0] vmin [0:3] = '{`CMS_V1_MIN, `CMS_V2_MIN, `CMS_V3_MIN, `CMS_V4_MIN};
  int errors = 0;
  int tests_run = 0;
  int n, k, j;
  cms_sense_model u_sense (.clk_in(clk_in), .plug_in(plug), .surge_in(surge),
    .batt_mv_in(batt_mv), .minsys_mv_in(minsys_mv), .conv_out(conv), .ovp_out(ovp),
    .rail_mv_out(rail), .below_minsys_out(b_min), .below_3v_out(b_3v));
  cms_sequencer #(.GOOD_CYCLES(GOOD), .DEBOUNCE_CYCLES(DEB), .AWAKE_CYCLES(AWK)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .adapter_conv_in(conv),
    .adapter_ovp_in(ovp), .battery_uvlo_ok_in(1'b1), .batt_below_minsys_in(b_min),
    .batt_below_3v_in(b_3v), .battery_config_pin_low_in(cfg_low),
    .cell_count_sense_pin_in(cells), .adapter_rail_mv_in(rail),
    .current_limit_pin_below_lo_in(pin_lo), .current_limit_pin_above_hi_in(pin_hi),
    .current_limit_pin_above_4v_in(pin_4v), .current_limit_pin_ma_in(pin_ma),
    .adapter_good_output_out(good), .converter_run_out(run), .poor_source_detect_out(psd),
    .battery_switch_on_out(sw_on), .battery_switch_linear_out(sw_lin),
    .gate_drive_supply_full_out(gdrv), .monitors_allowed_out(), .high_impedance_out(hiz),
    .input_current_regulation_ma_out(ilim), .charge_current_ma_out(chg),
    .system_target_mv_out(tgt), .system_target_tracks_batt_out(trk));
  initial forever #20 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_in) begin
    rd_d <= rd;
    if (rd_d) begin
      q_exp = exp_q.pop_front();
      `CHK("rdata", q_exp, rdata)
    end
  end
  // One register cycle; the gap edge keeps strobes single-driven
  task bus(input w, input [7:0] a, input [15:0] d);
    if (!w) exp_q.push_back(d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_in);
  endtask
  // Bounded wait for good (0) or run (1), counted in cycles
  task wt(input int i, output int c);
    c = 0;
    while (c < 400) begin
      @(negedge clk_in);
      if (st[i]) break;
      c++;
    end
  endtask
  // Adapter attach with cell code, pin level and expected start
  task pwr(input [1:0] c, input lo, input go);
    cells <= c;
    pin_lo <= lo;
    pin_hi <= !lo;
    plug <= 1'b1;
    wt(0, n);
    `CHK("good_time", 1'b1, n >= GOOD + 2 && n <= GOOD + 4)
    wt(1, n);
    `CHK("run_time", go, n >= DEB + 1 && n <= DEB + 4)
    @(posedge clk_in);
  endtask
  task report_and_stop;
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #(40 * 12000);
    errors++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    n = $urandom(63);
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    bus(0, `CMS_OFF_OPT0, 16'h0004);
    bus(0, `CMS_OFF_OPT1, 16'h0080);
    bus(0, `CMS_OFF_CHG_I, 16'h0000);
    bus(0, `CMS_OFF_CHG_V, `CMS_V1_CHG);
    bus(0, `CMS_OFF_HOST_INPUT_CURRENT_LIMIT, 16'h0042);
    bus(0, `CMS_OFF_AWAKE, 16'h0001);
    bus(0, `CMS_OFF_SYSTEM_OVERVOLTAGE_THRESHOLD, `CMS_V1_OVP);
    bus(0, 8'h7E, 16'h0000);
    `CHK("sw_on", 1'b1, sw_on)
    `CHK("gdrv", 1'b0, gdrv)
    bus(1, `CMS_OFF_OPT1, 16'h0000);
    `CHK("gdrv", 1'b1, gdrv)
    code = $urandom % 127 + 1;
    bus(1, `CMS_OFF_HOST_INPUT_CURRENT_LIMIT, code);
    `CHK("ilim", code * `CMS_IIN_STEP_MA, ilim)
    // Adapter above its overvoltage level is never reported good
    surge <= 1'b1;
    plug <= 1'b1;
    repeat (GOOD + 10) @(posedge clk_in);
    `CHK("good_ovp", 1'b0, good)
    plug <= 1'b0;
    surge <= 1'b0;
    repeat (4) @(posedge clk_in);
    // Every cell count, each ending auto-wake a different way
    for (k = 3; k >= 0; k--) begin
      minsys_mv <= vmin[k];
      batt_mv <= vmin[k] - 16'h0100;
      pin_ma <= $urandom % 4000 + 100;
      bus(1, `CMS_OFF_AWAKE, 16'h0001);
      pwr(k[1:0], 1'b0, 1'b1);
      `CHK("wake_i", `CMS_AWAKE_I_MA, chg)
      `CHK("ilim", (pin_ma < code * 50) ? pin_ma : code * `CMS_IIN_STEP_MA, ilim)
      `CHK("psd", 1'b1, psd)
      `CHK("sys_tgt", vmin[k] + `CMS_SYS_MARGIN_MV, tgt)
      `CHK("linear", 1'b1, sw_lin)
      bus(0, `CMS_OFF_CHG_V, vchg[k]);
      bus(0, `CMS_OFF_MINSYS, vmin[k]);
      bus(1, `CMS_OFF_SYSTEM_OVERVOLTAGE_THRESHOLD, 16'h1234);
      bus(0, `CMS_OFF_SYSTEM_OVERVOLTAGE_THRESHOLD, `CMS_V4_OVP);
      bus(0, `CMS_OFF_VIN_REG, 16'h4E20);
      v = $urandom;
      bus(1, `CMS_OFF_VIN_REG, v);
      bus(0, `CMS_OFF_VIN_REG, v);
      case (k)
        3: repeat (AWK + 5) @(posedge clk_in);
        2: bus(1, `CMS_OFF_AWAKE, 16'h0000);
        1: bus(1, `CMS_OFF_CHG_I, 16'h0200);
        default: batt_mv <= vmin[k] + 16'h0100;
      endcase
      repeat (4) @(posedge clk_in);
      bus(0, `CMS_OFF_AWAKE, 16'h0000);
      bus(0, `CMS_OFF_CHG_I, 16'h0000);
      for (j = 0; j < 2; j++) begin
        batt_mv <= j ? vmin[k] - 16'h0100 : 16'h0A00;
        bus(1, `CMS_OFF_CHG_I, 16'h0FA0);
        `CHK("clamp", (k == 0 && j) ? `CMS_CLAMP_HI_MA : `CMS_CLAMP_LO_MA, chg)
      end
      batt_mv <= vmin[k] + 16'h0100;
      bus(1, `CMS_OFF_OPT0, 16'h0005);
      `CHK("inhibit", 16'h0000, chg)
      `CHK("sw_off", 1'b0, sw_on)
      `CHK("tracks", 1'b1, trk)
      bus(1, `CMS_OFF_OPT0, 16'h0004);
      if (k == 2) begin
        cfg_low <= 1'b1;
        @(posedge clk_in);
        bus(0, `CMS_OFF_CHG_I, 16'h0000);
        cfg_low <= 1'b0;
      end
      if (k == 0) begin
        bus(1, `CMS_OFF_CHG_V, 16'h0000);
        bus(0, `CMS_OFF_CHG_V, vchg[k]);
        bus(0, `CMS_OFF_CHG_I, 16'h0000);
      end
      bus(1, `CMS_OFF_CHG_I, 16'h0FA0);
      plug <= 1'b0;
      repeat (4) @(posedge clk_in);
      bus(0, `CMS_OFF_CHG_I, 16'h0000);
    end
    // Host bit sets high-impedance mode: no switching, battery switch held on
    bus(1, `CMS_OFF_HIZCTL, 16'h0080);
    `CHK("hiz", 1'b1, hiz)
    batt_mv <= vmin[0] - 16'h0100;
    plug <= 1'b1;
    repeat (GOOD + DEB + 10) @(posedge clk_in);
    `CHK("hiz_run", 1'b0, run)
    `CHK("hiz_sw", 1'b1, sw_on)
    `CHK("hiz_psd", 1'b0, psd)
    bus(1, `CMS_OFF_OPT0, 16'h0000);
    bus(1, `CMS_OFF_AWAKE, 16'h0000);
    bus(0, `CMS_OFF_CHG_V, vchg[0]);
    bus(1, `CMS_OFF_CHG_I, 16'h0FA0);
    bus(1, `CMS_OFF_HIZCTL, 16'h0000);
    @(posedge clk_in);
    `CHK("hiz_off_run", 1'b1, run)
    `CHK("no_clamp", 16'h0FA0, chg)
    `CHK("no_linear", 1'b0, sw_lin)
    plug <= 1'b0;
    repeat (4) @(posedge clk_in);
    pwr(2'h0, 1'b1, 1'b0);
    `CHK("pin_hiz", 1'b1, hiz)
    plug <= 1'b0;
    repeat (4) @(posedge clk_in);
    bus(1, `CMS_OFF_PINCTL, 16'h0000);
    pwr(2'h0, 1'b1, 1'b1);
    `CHK("pin_off", code * `CMS_IIN_STEP_MA, ilim)
    // Pin above 4V is ignored even with the pin enabled
    plug <= 1'b0;
    pin_4v <= 1'b1;
    bus(1, `CMS_OFF_PINCTL, 16'h0080);
    pwr(2'h0, 1'b1, 1'b1);
    bus(0, `CMS_OFF_IIN_EFF, code * `CMS_IIN_STEP_MA);
    bus(0, `CMS_OFF_STATUS, 16'h0047);
    repeat (4) @(posedge clk_in);
    report_and_stop();
  end
endmodule
